// ===== design/interrupt_mask_control.v
`timescale 1ns/1ps
`include "irq_mask_defines.vh"
// What this block does
// - bit 8 set: pulse interrupt output repeatedly while any interrupt is pending
// - bit 7 set: watchdog kept off in software development mode
// - bit 6 set: one pulse on watchdog trigger failure in development mode
// - bit 5 set: one pulse on serial frame or checksum fault
// - bit 4 set: one pulse when bridge-driver status flag sets
// - bit 3 set: one pulse when high-side status flag sets
// - bit 2 set: one pulse when bus status flag sets
// - bit 1 set: one pulse when temperature status flag sets
// - bit 0 set: one pulse when supply status flag sets
// - every enabled event pulses unless a pulse is already running, even if its status bit was already set
// - bits 15 to 9 always read as zero
// - power-on/soft reset loads 0x0140; restart clears 15:9, keeps 8:0
module interrupt_mask_control #(
    parameter PERIOD_CYC = `PERIOD_US * `CLK_MHZ
) (
    input  wire        clock,
    input  wire        sys_rst,
    input  wire        softRst,
    input  wire        restartRst,
    input  wire        regWrite,
    input  wire [6:0]  regAddr,
    input  wire [15:0] regWdata,
    output reg  [15:0] regRdata,
    input  wire        supplyEvt,
    input  wire        tempEvt,
    input  wire        busEvt,
    input  wire        highsideEvt,
    input  wire        bridgeEvt,
    input  wire        frameFaultEvt,
    input  wire        crcFaultEvt,
    input  wire        wdFailEvt,
    input  wire        devMode,
    input  wire        irqPending,
    output reg         watchdogActive,
    output wire        irq_out_n
);
    // ==========================================
    // design notes
    // - all event inputs are one-clock pulses from logic on this clock,
    //   so they are used without synchronising flops
    // - one pulse generator serves every source; events that land while a
    //   pulse runs merge into it, the host reads status to see them all
    // - the re-signal timer holds at its last count while a pulse runs,
    //   so a periodic reminder is delayed rather than lost
    // - a restart keeps the stored enables; only power-on and soft reset
    //   bring back the default enables

    // ==========================================
    // constants
    // pulse length rounded up to whole clocks so a slow clock never shortens it
    localparam PULSE_CYC_RAW = (`PULSE_NS * `CLK_MHZ + `NS_ROUND_UP) / `NS_PER_US;
    localparam PULSE_CYC     = (PULSE_CYC_RAW < 1) ? 1 : PULSE_CYC_RAW;
    // last count of the re-signal timer; a period of one clock fires every cycle the generator is free
    localparam PERIOD_LAST   = PERIOD_CYC - 1;
    localparam TICK_W        = 32;

    // ==========================================
    // functions
    // address match for the only register of this block
    function maskSelected;
        input [6:0] addr;
        begin
            maskSelected = (addr == `MASK_ADDR);
        end
    endfunction

    // timer at or past its last count; the compare is shared by timer and fire
    function periodReached;
        input [TICK_W-1:0] tick;
        begin
            periodReached = (tick >= PERIOD_LAST);
        end
    endfunction

    // keep the implemented bits only; reserved bits can never be stored
    function [15:0] liveBits;
        input [15:0] word;
        begin
            liveBits = word & `MASK_LIVE_BITS;
        end
    endfunction

    // ==========================================
    // declarations
    reg  [15:0]       mask_r;
    reg  [15:0]       mask_nxt;
    reg  [15:0]       rdata_nxt;
    reg               wdActive_nxt;
    reg  [TICK_W-1:0] tick_r;
    reg  [TICK_W-1:0] tick_nxt;
    wire              maskHit;
    wire              supplyHit;
    wire              tempHit;
    wire              busHit;
    wire              highsideHit;
    wire              bridgeHit;
    wire              serialHit;
    wire              wdFailHit;
    wire              evtFire;
    wire              timerRun;
    wire              periodicFire;
    wire              pulseBusy;

    // ==========================================
    // register write decode
    assign maskHit = regWrite && maskSelected(regAddr);

    // mask next value; all three reset kinds, restart included, outrank a write in the same cycle
    always @* begin
        mask_nxt = mask_r;
        if (sys_rst || softRst) begin
            mask_nxt = `MASK_RST_VAL;
        end else if (restartRst) begin
            mask_nxt = liveBits(mask_r);
        end else if (maskHit) begin
            mask_nxt = liveBits(regWdata);
        end
    end

    // mask storage; status flags live elsewhere, so a set flag never blocks an event
    always @(posedge clock) begin
        mask_r <= mask_nxt;
    end

    // ==========================================
    // read path
    // other addresses read zero so an unmapped read never echoes the mask
    always @* begin
        rdata_nxt = 16'h0000;
        if (maskSelected(regAddr)) begin
            rdata_nxt = liveBits(mask_r);
        end
    end

    // read data from flops; one clock of latency after the address
    always @(posedge clock) begin
        if (sys_rst) begin
            regRdata <= 16'h0000;
        end else begin
            regRdata <= rdata_nxt;
        end
    end

    // ==========================================
    // watchdog gate
    // off only while in development mode with the disable bit set
    always @* begin
        wdActive_nxt = ~(devMode & mask_r[`BIT_WD_OFF]);
    end

    // registered so the watchdog never sees a glitch from the mode input
    always @(posedge clock) begin
        if (sys_rst) begin
            watchdogActive <= 1'b1;
        end else begin
            watchdogActive <= wdActive_nxt;
        end
    end

    // ==========================================
    // event qualification
    // each input pulse is one event; a level held high fires again each time the generator is free
    assign supplyHit   = supplyEvt & mask_r[`BIT_SUPPLY];
    assign tempHit     = tempEvt & mask_r[`BIT_TEMP];
    assign busHit      = busEvt & mask_r[`BIT_BUS];
    assign highsideHit = highsideEvt & mask_r[`BIT_HIGHSIDE];
    assign bridgeHit   = bridgeEvt & mask_r[`BIT_BRIDGE];
    assign serialHit   = (frameFaultEvt | crcFaultEvt) & mask_r[`BIT_SERIAL];
    assign wdFailHit   = wdFailEvt & devMode & mask_r[`BIT_WD_FAIL];

    // any enabled source fires; status history plays no part
    assign evtFire = supplyHit | tempHit | busHit | highsideHit
                   | bridgeHit | serialHit | wdFailHit;

    // ==========================================
    // periodic re-signalling
    // the timer runs only while enabled and something is pending
    assign timerRun = mask_r[`BIT_PERIODIC] & irqPending;

    // at the last count the timer waits out a running pulse
    always @* begin
        if (!timerRun) begin
            tick_nxt = {TICK_W{1'b0}};
        end else if (periodReached(tick_r)) begin
            tick_nxt = pulseBusy ? tick_r : {TICK_W{1'b0}};
        end else begin
            tick_nxt = tick_r + {{(TICK_W-1){1'b0}}, 1'b1};
        end
    end

    // timer storage; cleared by reset, otherwise follows its next value
    always @(posedge clock) begin
        if (sys_rst) begin
            tick_r <= {TICK_W{1'b0}};
        end else begin
            tick_r <= tick_nxt;
        end
    end

    // reminder fires only when the generator is free to take it
    assign periodicFire = timerRun & periodReached(tick_r) & ~pulseBusy;

    // ==========================================
    // pulse shaping
    // the generator is shared, so its busy flag also paces the reminder
    irq_pulse_gen #(
        .LEN     (PULSE_CYC)
    ) u_pulse (
        .clock   (clock),
        .sys_rst (sys_rst),
        .fire    (evtFire | periodicFire),
        .busy    (pulseBusy),
        .irqOutN (irq_out_n)
    );
endmodule

// ===== design/irq_mask_defines.vh
`ifndef IRQ_MASK_DEFINES_VH
`define IRQ_MASK_DEFINES_VH
// ==========================================
// register map
`define MASK_ADDR        7'h09
`define MASK_RST_VAL     16'h0140
`define MASK_LIVE_BITS   16'h01ff
// ==========================================
// field positions
`define BIT_SUPPLY       0
`define BIT_TEMP         1
`define BIT_BUS          2
`define BIT_HIGHSIDE     3
`define BIT_BRIDGE       4
`define BIT_SERIAL       5
`define BIT_WD_FAIL      6
`define BIT_WD_OFF       7
`define BIT_PERIODIC     8
// ==========================================
// timing
`define PULSE_NS         100
`define PERIOD_US        1000
`define CLK_MHZ          40
`define NS_PER_US        1000
`define NS_ROUND_UP      999
`endif

// ===== design/irq_pulse_gen.v
`timescale 1ns/1ps
// ==========================================
// fixed-length low pulse generator
module irq_pulse_gen #(
    parameter LEN = 4
) (
    input  wire clock,
    input  wire sys_rst,
    input  wire fire,
    output wire busy,
    output reg  irqOutN
);
    reg [15:0] cnt_r;

    // count down; a fire while busy is merged into the running pulse
    always @(posedge clock) begin
        if (sys_rst) begin
            cnt_r   <= 16'h0000;
            irqOutN <= 1'b1;
        end else if (fire && cnt_r == 16'h0000) begin
            cnt_r   <= LEN[15:0];
            irqOutN <= 1'b0;
        end else if (cnt_r != 16'h0000) begin
            cnt_r   <= cnt_r - 16'h0001;
            irqOutN <= (cnt_r == 16'h0001);
        end else begin
            irqOutN <= 1'b1;
        end
    end

    assign busy = (cnt_r != 16'h0000);
endmodule

// ===== test/irq_mask_assertions.sv
`timescale 1ns/1ps
// ====
// port checker
module irq_mask_checker (
    input wire        clock, sys_rst, regWrite, devMode, irqPending, watchdogActive, irq_out_n,
    input wire        supplyEvt, tempEvt, busEvt, highsideEvt, bridgeEvt, frameFaultEvt, crcFaultEvt, wdFailEvt,
    input wire [6:0]  regAddr,
    input wire [15:0] regWdata, regRdata
);
    // causes other than supply and watchdog
    wire five = tempEvt | busEvt | highsideEvt | bridgeEvt | frameFaultEvt | crcFaultEvt | irqPending;
    wire anyEvt = five | supplyEvt | wdFailEvt;
    wire atMask = regAddr == 7'h09 && !regWrite;
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    sequence wr_s; regWrite && regAddr == 7'h09; endsequence
    // read data lags a cycle, so the mask must be settled one cycle back
    sequence lone_s(b); supplyEvt && !five && !wdFailEvt && irq_out_n && $past(atMask) && regRdata[0] == b; endsequence
    rsv_zero_a: assert property (regRdata[15:9] == 7'h00) else $error("reserved bits read set");
    write_back_a: assert property (wr_s ##1 atMask |=> regRdata == ($past(regWdata, 2) & 16'h01ff)) else $error("bad readback");
    pulse_len_a: assert property ($fell(irq_out_n) |-> !irq_out_n [*4] ##1 irq_out_n) else $error("bad pulse length");
    pulse_cause_a: assert property ($fell(irq_out_n) |-> $past(anyEvt)) else $error("pulse without cause");
    supply_on_a: assert property (lone_s(1'b1) |=> !irq_out_n) else $error("supply pulse missing");
    supply_off_a: assert property (lone_s(1'b0) |=> irq_out_n) else $error("masked supply pulsed");
    wd_mode_a: assert property (wdFailEvt && !devMode && !five && !supplyEvt && irq_out_n |=> irq_out_n) else $error("wd pulse off mode");
    wd_on_a: assert property (!$past(devMode) |-> watchdogActive) else $error("watchdog off outside mode");
endmodule
bind interrupt_mask_control irq_mask_checker chk (.*);

// ===== test/mcu_model.sv
`timescale 1ns/1ps
// ====
// microcontroller side of the register path
module mcu_model (
    input  wire        clock,
    input  wire [15:0] regRdata,
    output reg         regWrite = 1'b0,
    output reg  [6:0]  regAddr = 7'h09,
    output reg  [15:0] regWdata = 16'h0000
);
    // released data is inverted so a stale value is never mistaken for a write
    task put(input [6:0] a, input [15:0] d);
        @(negedge clock) {regWrite, regAddr, regWdata} = {1'b1, a, d};
        @(negedge clock) {regWrite, regAddr, regWdata} = {1'b0, 7'h09, ~d};
    endtask
    task get(input [6:0] a, output [15:0] d);
        @(negedge clock) regAddr = a;
        @(negedge clock) d = regRdata;
        regAddr = 7'h09;
    endtask
endmodule

// ===== test/interrupt_mask_control_bench.sv
`timescale 1ns/1ps
module interrupt_mask_control_bench;
    reg clock = 1'b0, sys_rst = 1'b1, softRst = 1'b0, restartRst = 1'b0, devMode = 1'b0, irqPending = 1'b0, e;
    reg [7:0] evts = 8'h00;
    reg lastIrq = 1'b1;
    reg [15:0] d, m;
    integer seed = 32'h8c7220cd, fails = 0, n_compared = 0, i, j;
    bit q[$];
    wire regWrite, watchdogActive, irq_out_n;
    wire [6:0] regAddr;
    wire [15:0] regWdata, regRdata;
    mcu_model mcu (.clock(clock), .regRdata(regRdata), .regWrite(regWrite), .regAddr(regAddr), .regWdata(regWdata));
    interrupt_mask_control #(.PERIOD_CYC(20)) dut (.clock(clock), .sys_rst(sys_rst), .softRst(softRst),
        .restartRst(restartRst), .regWrite(regWrite), .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
        .supplyEvt(evts[0]), .tempEvt(evts[1]), .busEvt(evts[2]), .highsideEvt(evts[3]), .bridgeEvt(evts[4]),
        .frameFaultEvt(evts[5]), .crcFaultEvt(evts[6]), .wdFailEvt(evts[7]), .devMode(devMode),
        .irqPending(irqPending), .watchdogActive(watchdogActive), .irq_out_n(irq_out_n));
    initial forever #12.5 clock = ~clock;
    task check(input string w, input [15:0] x, input [15:0] g);
        n_compared++;
        if (x !== g) begin
            fails++;
            $display("Error %s expected %h seen %h", w, x, g);
        end
    endtask
    task conclude;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // one-cycle event, then room for the whole pulse
    task fire(input integer k);
        @(negedge clock) evts[k] = 1'b1;
        @(negedge clock) evts = 8'h00;
        repeat (6) @(negedge clock);
    endtask
    // pulse watcher: every falling edge must consume a note
    always @(negedge clock) begin
        if (lastIrq === 1'b1 && irq_out_n === 1'b0) check("unexpected pulse", 16'h0000, 16'(q.size() == 0));
        if (lastIrq === 1'b1 && irq_out_n === 1'b0 && q.size() > 0) void'(q.pop_front());
        lastIrq <= irq_out_n;
    end
    initial begin
        repeat (5) @(negedge clock);
        sys_rst = 1'b0;
        mcu.get(7'h09, d);
        check("mask reset", 16'h0140, d);
        mcu.put(7'h09, 16'hffff);
        mcu.put(7'h0a, 16'h0000);
        mcu.get(7'h0a, d);
        check("unmapped", 16'h0000, d);
        mcu.get(7'h09, d);
        check("mask", 16'h01ff, d);
        for (i = 0; i < 40; i++) begin
            j = i % 8;
            m = $random(seed) & 16'h00ff;
            devMode = m[0] ^ m[7] ^ i[3];
            mcu.put(7'h09, m);
            e = m[j < 5 ? j : (j < 7 ? 5 : 6)] && (j != 7 || devMode);
            // the same event twice: the second must pulse as well
            repeat (2) begin
                if (e) q.push_back(1'b1);
                fire(j);
            end
            check("missing pulses", 16'h0000, 16'(q.size()));
            check("watchdog", 16'(!(devMode && m[7])), 16'(watchdogActive));
        end
        for (i = 1; i >= 0; i--) begin
            mcu.put(7'h09, 16'(i) << 8);
            irqPending = 1'b1;
            if (i == 1) q = '{1'b1, 1'b1};
            repeat (50) @(negedge clock);
            irqPending = 1'b0;
            repeat (6) @(negedge clock);
            check("periodic pulses", 16'h0000, 16'(q.size()));
        end
        mcu.put(7'h09, 16'h00aa);
        @(negedge clock) restartRst = 1'b1;
        @(negedge clock) restartRst = 1'b0;
        mcu.get(7'h09, d);
        check("after restart", 16'h00aa, d);
        @(negedge clock) softRst = 1'b1;
        @(negedge clock) softRst = 1'b0;
        mcu.get(7'h09, d);
        check("after soft reset", 16'h0140, d);
        conclude;
    end
endmodule
